// File: rtl/pps_pkg.sv
// Purpose: Constants and types for the passive parallel slave port.
// Assumes: APB register access, one 10 MHz clock.
// Notes:   Register indices are kept as printed; byte address = 4 * index.
// Function
// R1: Deselected: ignore strobes, release data, no action
// R2: Both strobes high: release data, no transfer
// R3: Address low means data, high means command/status
// R4: Write strobe, address high: latch command byte
// R5: Write strobe, address low: latch data byte
// R6: Read strobe, address high: drive status register
// R7: Read strobe, address low: drive read byte
// R8: Host registers replace shared port B storage
// R9: Host irq pin is status bit7 OR porta bit3
// R10: Host read sets config bit 7, W1C
// R11: Host write sets config bit 6, W1C
// R12: Config bit 5 shows last write was command
// R13: Config bits 3,2,1 enable read/data/command irqs
// R14: Config bit 0 enables port, else silent
// R15: Eight data lines, four controls, one irq
// R16: Synchronise pins; act on trailing strobe edge
// R17: Host keeps address and data stable meanwhile
package pps_pkg;
    // Printed register offsets, used as word indices
    localparam logic [31:0] IDX_CFG      = 32'h4000101C;
    localparam logic [31:0] IDX_RD_STAT  = 32'h40001096;
    localparam logic [31:0] IDX_WR_BYTE  = 32'h40001097;
    localparam logic [31:0] IDX_RD_BYTE  = 32'h400010C8;
    localparam logic [31:0] IDX_IRQ_STAT = 32'h400010D0;
    localparam logic [31:0] IDX_IRQ_MASK = 32'h400010D1;
    localparam int          IDX_BITS     = 12;
    // Configuration register fields
    localparam int CFG_RD_FLAG  = 7;
    localparam int CFG_WR_FLAG  = 6;
    localparam int CFG_CMD_FLAG = 5;
    localparam int CFG_IE_RD    = 3;
    localparam int CFG_IE_WR    = 2;
    localparam int CFG_IE_CMD   = 1;
    localparam int CFG_ENABLE   = 0;
    localparam logic [7:0] CFG_RW_MASK = 8'h0F;
    // Interrupt status and mask fields
    localparam int EV_RD  = 0;
    localparam int EV_DAT = 1;
    localparam int EV_CMD = 2;
    localparam int EV_W   = 3;
    // Host irq pin sources
    localparam int STAT_IRQ_BIT = 7;
    // Reset values
    localparam logic [7:0]      RST_BYTE = 8'h00;
    localparam logic [EV_W-1:0] RST_EV   = 3'h0;
    // Host pin sample
    typedef struct packed {
        logic       sel_n;
        logic       wr_n;
        logic       rd_n;
        logic       a0;
        logic [7:0] data;
    } pps_pins_type;
    localparam pps_pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
endpackage : pps_pkg

// File: rtl/pps_top.sv
// Purpose: Passive 8-bit parallel slave port with APB register access.
// Assumes: Host pins are asynchronous; held stable while strobes are low.
// Notes:   Pin response lags the pins by three ref_clk cycles.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pps_top
    import pps_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic        pready,
    output var  logic [31:0] prdata,
    output var  logic        pslverr,
    input  wire logic        port_select_n,
    input  wire logic        write_strobe_n,
    input  wire logic        read_strobe_n,
    input  wire logic        cmd_data_select,
    input  wire logic [7:0]  host_data_lines_in,
    output var  logic [7:0]  host_data_lines_out,
    output var  logic        host_data_lines_oe,
    output var  logic        host_irq_n,
    input  wire logic        porta_irq_bit,
    output var  logic        cpu_irq
);

    // Register index match on the word address
    function automatic logic hit(input logic [31:0] a,
                                 input logic [31:0] idx);
        hit = (a[IDX_BITS+1:2] == idx[IDX_BITS-1:0]);
    endfunction

    pps_pins_type    pin_s1;
    pps_pins_type    pin_s2;
    logic [7:0]      cfg;
    logic            cmd_flag;
    logic [7:0]      rd_stat;
    logic [7:0]      rd_byte;
    logic [7:0]      wr_byte;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_mask;
    logic            wr_prev;
    logic            rd_prev;
    logic [7:0]      cap_data;
    logic            cap_a0;
    logic            port_on;
    logic            wr_act;
    logic            rd_act;
    logic            wr_done;
    logic            rd_done;
    logic            apb_do;
    logic            apb_wr;
    logic            mapped;
    logic [7:0]      next_cfg;
    logic [EV_W-1:0] next_ev;
    logic [EV_W-1:0] ev_set;
    logic [7:0]      cfg_view;

    // Two-stage synchroniser for all host pins
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pin_s1 <= PINS_IDLE;
            pin_s2 <= PINS_IDLE;
        end
        else
        begin
            pin_s1 <= '{port_select_n, write_strobe_n, read_strobe_n,
                        cmd_data_select, host_data_lines_in}; // see R15
            pin_s2 <= pin_s1; // see R16
        end
    end

    // Access decode on synchronised pins
    assign port_on = cfg[CFG_ENABLE]; // see R14
    // Write wins over read strobe level
    assign wr_act  = port_on && !pin_s2.sel_n && !pin_s2.wr_n; // see R4
    // Read only with write strobe high
    assign rd_act  = port_on && !pin_s2.sel_n && pin_s2.wr_n
                     && !pin_s2.rd_n; // see R6
    // Deselect also ends an access
    assign wr_done = wr_prev && !wr_act; // see R16
    assign rd_done = rd_prev && !rd_act; // see R16

    // Strobe history and write capture
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wr_prev  <= 1'b0;
            rd_prev  <= 1'b0;
            cap_data <= RST_BYTE;
            cap_a0   <= 1'b0;
        end
        else
        begin
            wr_prev <= wr_act;
            rd_prev <= rd_act;
            // Last sample before the trailing edge is kept
            if (wr_act)
            begin
                cap_data <= pin_s2.data; // see R17
                cap_a0   <= pin_s2.a0; // see R3
            end
        end
    end

    // Written byte and its command/data class
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            wr_byte  <= RST_BYTE;
            cmd_flag <= 1'b0;
        end
        else if (wr_done)
        begin
            wr_byte  <= cap_data; // see R4 see R5 see R8
            cmd_flag <= cap_a0; // see R12
        end
    end

    // Data line drive, registered so pins come from flops
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            host_data_lines_out <= RST_BYTE;
            host_data_lines_oe  <= 1'b0;
        end
        else
        begin
            host_data_lines_oe <= rd_act; // see R1 see R2 see R14
            if (rd_act)
                host_data_lines_out <= pin_s2.a0 ? rd_stat // see R6
                                                 : rd_byte; // see R7
        end
    end

    // APB access phase; one wait state then ready
    assign apb_do = psel && penable && pready;
    assign apb_wr = apb_do && pwrite;
    assign mapped = hit(paddr, IDX_CFG) || hit(paddr, IDX_RD_STAT)
                    || hit(paddr, IDX_WR_BYTE) || hit(paddr, IDX_RD_BYTE)
                    || hit(paddr, IDX_IRQ_STAT)
                    || hit(paddr, IDX_IRQ_MASK);

    // Configuration next value: set beats write-one clear
    always_comb
    begin
        next_cfg = cfg;
        if (apb_wr && hit(paddr, IDX_CFG))
        begin
            next_cfg[CFG_RD_FLAG] = cfg[CFG_RD_FLAG]
                                    && !pwdata[CFG_RD_FLAG];
            next_cfg[CFG_WR_FLAG] = cfg[CFG_WR_FLAG]
                                    && !pwdata[CFG_WR_FLAG];
            next_cfg[3:0] = pwdata[3:0] & CFG_RW_MASK[3:0];
        end
        if (rd_done)
            next_cfg[CFG_RD_FLAG] = 1'b1; // see R10
        if (wr_done)
            next_cfg[CFG_WR_FLAG] = 1'b1; // see R11
        next_cfg[5:4] = 2'h0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cfg <= RST_BYTE;
        else
            cfg <= next_cfg;
    end

    // Software view of config adds the live command flag
    always_comb
    begin
        cfg_view = cfg;
        cfg_view[CFG_CMD_FLAG] = cmd_flag; // see R12
    end

    // Host-visible status and read byte, written by software
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            rd_stat <= RST_BYTE;
            rd_byte <= RST_BYTE;
        end
        else
        begin
            if (apb_wr && hit(paddr, IDX_RD_STAT))
                rd_stat <= pwdata[7:0]; // see R8
            if (apb_wr && hit(paddr, IDX_RD_BYTE))
                rd_byte <= pwdata[7:0]; // see R8
        end
    end

    // Event status: hardware set wins over software clear
    always_comb
    begin
        ev_set = '0;
        ev_set[EV_RD]  = rd_done;
        ev_set[EV_DAT] = wr_done && !cap_a0;
        ev_set[EV_CMD] = wr_done && cap_a0;
        next_ev = ev_stat;
        if (apb_wr && hit(paddr, IDX_IRQ_STAT))
            next_ev = ev_stat & ~pwdata[EV_W-1:0];
        next_ev = next_ev | ev_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ev_stat <= RST_EV;
            ev_mask <= RST_EV;
        end
        else
        begin
            ev_stat <= next_ev;
            if (apb_wr && hit(paddr, IDX_IRQ_MASK))
                ev_mask <= pwdata[EV_W-1:0];
        end
    end

    // Processor interrupt, gated by mask and config enables
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            cpu_irq <= 1'b0;
        else
            cpu_irq <= (ev_stat[EV_RD] && ev_mask[EV_RD]
                        && cfg[CFG_IE_RD])
                    || (ev_stat[EV_DAT] && ev_mask[EV_DAT]
                        && cfg[CFG_IE_WR])
                    || (ev_stat[EV_CMD] && ev_mask[EV_CMD]
                        && cfg[CFG_IE_CMD]); // see R13
    end

    // Host irq pin idles high while the port is off
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            host_irq_n <= 1'b1;
        else
            host_irq_n <= !port_on || rd_stat[STAT_IRQ_BIT]
                          || porta_irq_bit; // see R9
    end

    // APB slave: ready one cycle into the access phase
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= 32'h00000000;
            if (psel && penable && !pready && !pwrite)
            begin
                if (hit(paddr, IDX_CFG))
                    prdata[7:0] <= cfg_view;
                else if (hit(paddr, IDX_RD_STAT))
                    prdata[7:0] <= rd_stat;
                else if (hit(paddr, IDX_WR_BYTE))
                    prdata[7:0] <= wr_byte;
                else if (hit(paddr, IDX_RD_BYTE))
                    prdata[7:0] <= rd_byte;
                else if (hit(paddr, IDX_IRQ_STAT))
                    prdata[EV_W-1:0] <= ev_stat;
                else if (hit(paddr, IDX_IRQ_MASK))
                    prdata[EV_W-1:0] <= ev_mask;
            end
        end
    end

    // Checks on pin behaviour and flags
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_off_no_drive: assert property ( // see R14
        !port_on |=> !host_data_lines_oe)
        else $error("data driven while port disabled");
    a_desel_no_drive: assert property ( // see R1
        pin_s2.sel_n |=> !host_data_lines_oe)
        else $error("data driven while deselected");
    a_idle_no_drive: assert property ( // see R2
        (!pin_s2.sel_n && pin_s2.wr_n && pin_s2.rd_n)
        |=> !host_data_lines_oe)
        else $error("data driven with both strobes high");
    a_status_read: assert property ( // see R6
        (rd_act && pin_s2.a0) |=> host_data_lines_oe
        && host_data_lines_out == $past(rd_stat))
        else $error("status byte not driven");
    a_data_read: assert property ( // see R7
        (rd_act && !pin_s2.a0) |=> host_data_lines_oe
        && host_data_lines_out == $past(rd_byte))
        else $error("read byte not driven");
    a_cmd_latch: assert property ( // see R4
        (wr_done && cap_a0) |=> wr_byte == $past(cap_data)
        && cmd_flag)
        else $error("command byte not latched");
    a_data_latch: assert property ( // see R5
        (wr_done && !cap_a0) |=> wr_byte == $past(cap_data)
        && !cmd_flag)
        else $error("data byte not latched");
    a_host_irq_pin: assert property ( // see R9
        port_on ##1 port_on |-> host_irq_n ==
        ($past(rd_stat[STAT_IRQ_BIT]) || $past(porta_irq_bit)))
        else $error("host irq pin wrong");
    a_read_flag: assert property ( // see R10
        rd_done |=> cfg[CFG_RD_FLAG] && ev_stat[EV_RD])
        else $error("read flag not set");
    a_write_flag: assert property ( // see R11
        wr_done |=> cfg[CFG_WR_FLAG])
        else $error("write flag not set");
    a_irq_gate: assert property ( // see R13
        !cfg[CFG_IE_RD] && !cfg[CFG_IE_WR] && !cfg[CFG_IE_CMD]
        |=> !cpu_irq)
        else $error("irq raised with enables clear");
    a_one_event: assert property ( // see R16
        wr_done |=> !wr_done)
        else $error("write event repeated");

    c_cmd_write: cover property (wr_done && cap_a0);
    c_data_write: cover property (wr_done && !cap_a0);
    c_status_read: cover property (rd_act && pin_s2.a0 ##1 rd_done);
    c_irq: cover property (!cpu_irq ##1 cpu_irq);

endmodule : pps_top
`default_nettype wire

// File: sim/pps_host_model.sv
// Purpose: Host processor model driving the parallel pins.
// Assumes: Data lines pulled up while nobody drives them.
// Notes:   Strobes stay 5 cycles low, 5 high, above the 3-cycle minimum.
`timescale 1ns/1ps
`default_nettype none
module pps_host_model
    import pps_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] bus,
    output var  pps_pins_type pins,
    output var  logic       drv_oe
);
    // Idle: deselected, strobes high, lines released
    initial
    begin
        pins = PINS_IDLE;
        drv_oe = 1'b0;
    end

    // One host access; read data is the bus level late in the strobe
    // On a write, both pulls the read strobe low too; on a read it
    // keeps both strobes high, a selected cycle with no transfer
    task automatic xfer(input logic wr, input logic cmd, input logic both,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        pins <= '{1'b0, ~wr, wr ^ both, cmd, d};
        drv_oe <= wr;
        repeat (5) @(posedge ref_clk);
        q = bus;
        // Address and data held until the strobe has risen
        pins <= '{1'b1, 1'b1, 1'b1, cmd, d};
        drv_oe <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask

    // Strobe pulse with select high; the device must stay silent
    task automatic desel(input logic wr, input logic [7:0] d,
                         output logic [7:0] q);
        @(posedge ref_clk);
        pins <= '{1'b1, ~wr, wr, 1'b0, d};
        drv_oe <= wr;
        repeat (5) @(posedge ref_clk);
        q = bus;
        pins <= PINS_IDLE;
        drv_oe <= 1'b0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // pps_host_model
`default_nettype wire

// File: sim/pps_top_tb_top.sv
// Purpose: Self-checking bench for the parallel slave port.
// Assumes: APB answers with one wait state; host model on the pins.
// Notes:   Host irq pin and cpu irq checked a few cycles after changes.
`timescale 1ns/1ps
`default_nettype none
module pps_top_tb_top;
    import pps_pkg::*;
    localparam logic [31:0] A_CFG = {IDX_CFG[29:0], 2'b00};
    localparam logic [31:0] A_ST  = {IDX_RD_STAT[29:0], 2'b00};
    localparam logic [31:0] A_WB  = {IDX_WR_BYTE[29:0], 2'b00};
    localparam logic [31:0] A_RB  = {IDX_RD_BYTE[29:0], 2'b00};
    localparam logic [31:0] A_IS  = {IDX_IRQ_STAT[29:0], 2'b00};
    localparam logic [31:0] A_IM  = {IDX_IRQ_MASK[29:0], 2'b00};
    logic ref_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic porta_irq_bit = 1;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic pready, pslverr, d_oe, host_irq_n, cpu_irq, h_oe;
    logic [7:0] d_out, bus, q;
    pps_pins_type pins;
    int bad_count = 0, cmp_count = 0;

    // Pull-up on the data lines when neither side drives
    assign bus = d_oe ? d_out : (h_oe ? pins.data : 8'hFF);

    pps_top dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .port_select_n(pins.sel_n),
        .write_strobe_n(pins.wr_n), .read_strobe_n(pins.rd_n),
        .cmd_data_select(pins.a0), .host_data_lines_in(bus),
        .host_data_lines_out(d_out), .host_data_lines_oe(d_oe),
        .host_irq_n(host_irq_n), .porta_irq_bit(porta_irq_bit),
        .cpu_irq(cpu_irq));
    pps_host_model hm (.ref_clk(ref_clk), .bus(bus), .pins(pins),
        .drv_oe(h_oe));

    // Free-running 10 MHz clock
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        // Sample pready at rising edges with the request still standing
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            $display("Error pready expected 1 seen %b", pready);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wreg(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rchk(input string n, input logic [31:0] a,
                        input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(n, x, r);
    endtask

    task automatic t_reset();
        rchk("cfg", A_CFG, 32'h0);
        rchk("rd_stat", A_ST, 32'h0);
        rchk("wr_byte", A_WB, 32'h0);
        rchk("rd_byte", A_RB, 32'h0);
        rchk("irq_stat", A_IS, 32'h0);
    endtask

    // Disabled port must not drive or flag
    task automatic t_off();
        wreg(A_ST, 32'h5A);
        hm.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
        chk("off read", 8'hFF, q);
        rchk("off cfg", A_CFG, 32'h0);
    endtask

    task automatic t_read();
        wreg(A_CFG, 32'h01);
        wreg(A_RB, 32'hC3);
        hm.xfer(1'b0, 1'b1, 1'b0, 8'h00, q);
        chk("status", 8'h5A, q);
        hm.xfer(1'b0, 1'b0, 1'b0, 8'h00, q);
        chk("data", 8'hC3, q);
        rchk("rd flag", A_CFG, 32'h81);
        wreg(A_CFG, 32'h81);
        rchk("rd clr", A_CFG, 32'h01);
        hm.xfer(1'b0, 1'b1, 1'b1, 8'h00, q);
        chk("idle read", 8'hFF, q);
        hm.desel(1'b0, 8'h00, q);
        chk("desel read", 8'hFF, q);
        hm.desel(1'b1, 8'h99, q);
        rchk("desel wr", A_WB, 32'h0);
        rchk("idle cfg", A_CFG, 32'h01);
    endtask

    // Command with read strobe also low, then data
    task automatic t_write();
        hm.xfer(1'b1, 1'b1, 1'b1, 8'h81, q);
        rchk("cmd byte", A_WB, 32'h81);
        rchk("cmd cfg", A_CFG, 32'h61);
        hm.xfer(1'b1, 1'b0, 1'b0, 8'h42, q);
        wreg(A_WB, 32'hFF);
        rchk("dat byte", A_WB, 32'h42);
        rchk("dat cfg", A_CFG, 32'h41);
        wreg(A_CFG, 32'h41);
        rchk("wr clr", A_CFG, 32'h01);
    endtask

    task automatic t_irq();
        wreg(A_IS, 32'h7);
        wreg(A_IM, 32'h7);
        wreg(A_CFG, 32'h03);
        hm.xfer(1'b1, 1'b0, 1'b0, 8'h11, q);
        chk("irq data off", 1'b0, cpu_irq);
        hm.xfer(1'b1, 1'b1, 1'b0, 8'h22, q);
        chk("irq cmd on", 1'b1, cpu_irq);
        wreg(A_IS, 32'h7);
        repeat (2) @(posedge ref_clk);
        chk("irq clr", 1'b0, cpu_irq);
        // Data write and host read enables, one at a time
        wreg(A_CFG, 32'h05);
        hm.xfer(1'b1, 1'b0, 1'b0, 8'h33, q);
        chk("irq dat on", 1'b1, cpu_irq);
        wreg(A_IS, 32'h7);
        wreg(A_CFG, 32'h09);
        hm.xfer(1'b0, 1'b0, 1'b0, 8'h00, q);
        chk("irq rd on", 1'b1, cpu_irq);
        wreg(A_IS, 32'h7);
    endtask

    // Host irq pin is status bit 7 or port A bit
    task automatic t_pin();
        logic [31:0] r;
        logic e;
        porta_irq_bit <= 1'b0;
        wreg(A_ST, 32'h80);
        repeat (2) @(posedge ref_clk);
        chk("pin st7", 1'b1, host_irq_n);
        wreg(A_ST, 32'h00);
        repeat (2) @(posedge ref_clk);
        chk("pin low", 1'b0, host_irq_n);
        porta_irq_bit <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk("pin pa3", 1'b1, host_irq_n);
        apb(1'b0, 32'h100, 32'h0, r, e);
        chk("unmapped err", 1'b1, e);
        chk("unmapped data", 32'h0, r);
    endtask

    task automatic stop_test();
        $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial
    begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_off();
        t_read();
        t_write();
        t_irq();
        t_pin();
        stop_test();
    end
endmodule // pps_top_tb_top
`default_nettype wire
